//--- verilog/jcd_map.vh
// Constants for the JTAG chain and debug sync block.
// Assumes inclusion by bare name from jcd_jtag_chain.v only.
`ifndef JCD_MAP_VH
`define JCD_MAP_VH

// =====================================================================
// Instruction register
// =====================================================================
`define JCD_IR_W            4
`define JCD_IR_CAPTURE      4'h1
`define JCD_INS_EXTEST      4'h0
`define JCD_INS_SAMPLE      4'h1
`define JCD_INS_DEVICE_IDENTIFICATION_WORD      4'h2
`define JCD_INS_USERCODE    4'h3
`define JCD_INS_ACCESS      4'h4
`define JCD_INS_BYPASS      4'hF

// =====================================================================
// Identification word layout
// =====================================================================
`define JCD_ID_VER_MSB      31
`define JCD_ID_VER_LSB      28
`define JCD_ID_PART_MSB     27
`define JCD_ID_PART_LSB     12
`define JCD_ID_MFR_MSB      11
`define JCD_ID_MFR_LSB      1
`define JCD_ID_FIXED_BIT    0

// =====================================================================
// User code word layout
// =====================================================================
`define JCD_UC_UID_MSB      31
`define JCD_UC_UID_LSB      16
`define JCD_UC_UNUSED_W     12
`define JCD_UC_REV_MSB      3
`define JCD_UC_REV_LSB      0

// =====================================================================
// Reset values and widths
// =====================================================================
`define JCD_WORD_W          32
`define JCD_SYNC_IDLE       1'b0
`define JCD_PIN_LOW         1'b0

`endif

//--- verilog/jcd_jtag_chain.v
// Three TAP controllers in series behind one four-wire test port,
// plus the open-drain debug synchronisation pin.
// Assumes TCK, TMS, TDI and the sync pin are asynchronous to mclk and
// that mclk runs well above TCK (50 MHz against a 160 ns TCK period).
`timescale 1ns/1ps
`default_nettype none
`include "jcd_map.vh"

// =====================================================================
// One TAP controller, sampled-edge style
// =====================================================================
module jcd_tap #(
    parameter        DW       = 32,
    parameter        HAS_BSR  = 0,
    parameter [31:0] ID_WORD  = 32'h0000_0001
) (
    input  wire          mclk,
    input  wire          rstn,
    input  wire          tck_rise,
    input  wire          tms,
    input  wire          tdi,
    input  wire [31:0]   user_word,
    input  wire [DW-1:0] cap_data,
    output reg           so,
    output reg  [DW-1:0] upd_data_reg,
    output reg           upd_pulse_reg,
    output reg           extest_reg,
    output wire          shifting
);
    localparam [15:0] S_TLR   = 16'h0001;
    localparam [15:0] S_RTI   = 16'h0002;
    localparam [15:0] S_SELDR = 16'h0004;
    localparam [15:0] S_CAPDR = 16'h0008;
    localparam [15:0] S_SHDR  = 16'h0010;
    localparam [15:0] S_EX1DR = 16'h0020;
    localparam [15:0] S_PADR  = 16'h0040;
    localparam [15:0] S_EX2DR = 16'h0080;
    localparam [15:0] S_UPDR  = 16'h0100;
    localparam [15:0] S_SELIR = 16'h0200;
    localparam [15:0] S_CAPIR = 16'h0400;
    localparam [15:0] S_SHIR  = 16'h0800;
    localparam [15:0] S_EX1IR = 16'h1000;
    localparam [15:0] S_PAIR  = 16'h2000;
    localparam [15:0] S_EX2IR = 16'h4000;
    localparam [15:0] S_UPIR  = 16'h8000;

    reg [15:0]           state_reg;
    reg [15:0]           state_next;
    reg [`JCD_IR_W-1:0]  ir_reg;
    reg [`JCD_IR_W-1:0]  ir_shift_reg;
    reg [31:0]           id_shift_reg;
    reg [DW-1:0]         acc_shift_reg;
    reg                  bypass_reg;
    wire                 id_sel;
    wire                 uc_sel;
    wire                 acc_sel;

    // Instruction decode; unknown codes fall to bypass
    assign id_sel   = (ir_reg == `JCD_INS_DEVICE_IDENTIFICATION_WORD);
    assign uc_sel   = (ir_reg == `JCD_INS_USERCODE);
    assign acc_sel  = (HAS_BSR != 0) ? ((ir_reg == `JCD_INS_EXTEST) || (ir_reg == `JCD_INS_SAMPLE))
                                     : (ir_reg == `JCD_INS_ACCESS);
    assign shifting = (state_reg == S_SHDR) || (state_reg == S_SHIR);

    // Standard TAP state walk; five TMS-high edges always reach TLR
    always @* begin
        case (state_reg)
            S_TLR:   state_next = tms ? S_TLR   : S_RTI;
            S_RTI:   state_next = tms ? S_SELDR : S_RTI;
            S_SELDR: state_next = tms ? S_SELIR : S_CAPDR;
            S_CAPDR: state_next = tms ? S_EX1DR : S_SHDR;
            S_SHDR:  state_next = tms ? S_EX1DR : S_SHDR;
            S_EX1DR: state_next = tms ? S_UPDR  : S_PADR;
            S_PADR:  state_next = tms ? S_EX2DR : S_PADR;
            S_EX2DR: state_next = tms ? S_UPDR  : S_SHDR;
            S_UPDR:  state_next = tms ? S_SELDR : S_RTI;
            S_SELIR: state_next = tms ? S_TLR   : S_CAPIR;
            S_CAPIR: state_next = tms ? S_EX1IR : S_SHIR;
            S_SHIR:  state_next = tms ? S_EX1IR : S_SHIR;
            S_EX1IR: state_next = tms ? S_UPIR  : S_PAIR;
            S_PAIR:  state_next = tms ? S_EX2IR : S_PAIR;
            S_EX2IR: state_next = tms ? S_UPIR  : S_SHIR;
            S_UPIR:  state_next = tms ? S_SELDR : S_RTI;
            default: state_next = S_TLR;
        endcase
    end

    // Serial output of the selected register
    always @* begin
        if (state_reg == S_SHIR) begin
            so = ir_shift_reg[0];
        end else if (id_sel || uc_sel) begin
            so = id_shift_reg[0];
        end else if (acc_sel) begin
            so = acc_shift_reg[0];
        end else begin
            so = bypass_reg;
        end
    end

    // State, capture, shift and update actions on each TCK rise
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= S_TLR;
            ir_reg        <= `JCD_INS_DEVICE_IDENTIFICATION_WORD;
            ir_shift_reg  <= {`JCD_IR_W{1'b0}};
            id_shift_reg  <= 32'h0000_0000;
            acc_shift_reg <= {DW{1'b0}};
            bypass_reg    <= 1'b0;
            upd_data_reg  <= {DW{1'b0}};
            upd_pulse_reg <= 1'b0;
            extest_reg    <= 1'b0;
        end else begin
            upd_pulse_reg <= 1'b0;
            if (tck_rise) begin
                state_reg <= state_next;
                if (state_next == S_TLR) begin
                    ir_reg     <= `JCD_INS_DEVICE_IDENTIFICATION_WORD;
                    extest_reg <= 1'b0;
                end
                case (state_reg)
                    S_CAPIR: begin
                        ir_shift_reg <= `JCD_IR_CAPTURE;
                    end
                    S_SHIR: begin
                        ir_shift_reg <= {tdi, ir_shift_reg[`JCD_IR_W-1:1]};
                    end
                    S_UPIR: begin
                        ir_reg     <= ir_shift_reg;
                        extest_reg <= (HAS_BSR != 0) && (ir_shift_reg == `JCD_INS_EXTEST);
                    end
                    S_CAPDR: begin
                        bypass_reg <= 1'b0;
                        if (id_sel) begin
                            id_shift_reg <= ID_WORD;
                        end else if (uc_sel) begin
                            id_shift_reg <= user_word;
                        end
                        if (acc_sel) begin
                            acc_shift_reg <= cap_data;
                        end
                    end
                    S_SHDR: begin
                        bypass_reg    <= tdi;
                        id_shift_reg  <= {tdi, id_shift_reg[31:1]};
                        acc_shift_reg <= {tdi, acc_shift_reg[DW-1:1]};
                    end
                    S_UPDR: begin
                        if (acc_sel) begin
                            upd_data_reg  <= acc_shift_reg;
                            upd_pulse_reg <= 1'b1;
                        end
                    end
                    default: begin
                        bypass_reg <= bypass_reg;
                    end
                endcase
            end
        end
    end
endmodule

// =====================================================================
// Chain top: debug TAP, boundary scan TAP, processor TAP
// =====================================================================
// Function
// - After reset, three TAP controllers sit in series on the chain.
// - The debug TAP reaches peripherals, including converter and USB block.
// - The boundary scan TAP is a standard controller scanning the I/O pins.
// - The processor TAP reaches tile, switch and OTP for loading and debug.
// - Five TCK cycles with TMS high return the TAP logic to reset.
// - The debug sync pin works as either an output or an input.
// - In output mode the pin is driven low once a breakpoint is hit.
// - In output mode the pin stays released until a breakpoint is hit.
// - In input mode, an outside low on the pin forces debug mode.
// - Software selects how the processor reacts to the sync pin.
// - DEVICE_IDENTIFICATION_WORD shifts out version, part, maker fields, least bit one.
module jcd_jtag_chain #(
    parameter        PER_W     = 32,
    parameter        TILE_W    = 32,
    parameter        BSR_W     = 16,
    parameter [3:0]  ID_VER    = 4'h1,       // Arbitrary value
    parameter [15:0] ID_PART   = 16'h0A5C,   // Arbitrary value
    parameter [10:0] ID_MFR    = 11'h2B4,    // Arbitrary value
    parameter [3:0]  SI_REV    = 4'h1        // Arbitrary value
) (
    input  wire              mclk,
    input  wire              rstn,
    input  wire              jtag_tck,
    input  wire              jtag_tms,
    input  wire              jtag_tdi,
    output reg               jtag_tdo,
    output reg               jtag_tdo_oe,
    input  wire              dbg_sync_in,
    output reg               dbg_sync_out,
    output reg               dbg_sync_oe,
    input  wire              sync_drive_en,
    input  wire              sync_listen_en,
    input  wire              bkpt_hit,
    output reg               force_debug,
    input  wire [15:0]       otp_user_id,
    input  wire [PER_W-1:0]  per_rd_data,
    output wire [PER_W-1:0]  per_wr_data,
    output wire              per_wr_stb,
    input  wire [TILE_W-1:0] tile_rd_data,
    output wire [TILE_W-1:0] tile_wr_data,
    output wire              tile_wr_stb,
    input  wire [BSR_W-1:0]  pin_in,
    output wire [BSR_W-1:0]  pin_out,
    output wire              pin_extest
);
    localparam [31:0] ID_WORD = {ID_VER, ID_PART, ID_MFR, 1'b1};

    reg         tck_s1_reg;
    reg         tck_s2_reg;
    reg         tck_s3_reg;
    reg         tms_s1_reg;
    reg         tms_s2_reg;
    reg         tdi_s1_reg;
    reg         tdi_s2_reg;
    reg         sync_s1_reg;
    reg         sync_s2_reg;
    wire        tck_rise;
    wire        tck_fall;
    wire        dbg_so;
    wire        bsr_so;
    wire        proc_so;
    wire [2:0]  shift_vec;
    wire [31:0] user_word;

    // Edge detect on the synchronised test clock
    assign tck_rise = tck_s2_reg & ~tck_s3_reg;
    assign tck_fall = ~tck_s2_reg & tck_s3_reg;

    // User word: OTP id, unused zeros, revision
    assign user_word = {otp_user_id, {`JCD_UC_UNUSED_W{1'b0}}, SI_REV};

    // Two-flop synchronisers for the test port and sync pin inputs
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tck_s1_reg  <= 1'b0;
            tck_s2_reg  <= 1'b0;
            tck_s3_reg  <= 1'b0;
            tms_s1_reg  <= 1'b1;
            tms_s2_reg  <= 1'b1;
            tdi_s1_reg  <= 1'b1;
            tdi_s2_reg  <= 1'b1;
            sync_s1_reg <= 1'b1;
            sync_s2_reg <= 1'b1;
        end else begin
            tck_s1_reg  <= jtag_tck;
            tck_s2_reg  <= tck_s1_reg;
            tck_s3_reg  <= tck_s2_reg;
            tms_s1_reg  <= jtag_tms;
            tms_s2_reg  <= tms_s1_reg;
            tdi_s1_reg  <= jtag_tdi;
            tdi_s2_reg  <= tdi_s1_reg;
            sync_s1_reg <= dbg_sync_in;
            sync_s2_reg <= sync_s1_reg;
        end
    end

    // Debug TAP, first on the chain, facing the peripherals
    jcd_tap #(.DW(PER_W), .HAS_BSR(0), .ID_WORD(ID_WORD)) u_dbg_tap (
        .mclk          (mclk),
        .rstn          (rstn),
        .tck_rise      (tck_rise),
        .tms           (tms_s2_reg),
        .tdi           (tdi_s2_reg),
        .user_word     (user_word),
        .cap_data      (per_rd_data),
        .so            (dbg_so),
        .upd_data_reg  (per_wr_data),
        .upd_pulse_reg (per_wr_stb),
        .extest_reg    (),
        .shifting      (shift_vec[0])
    );

    // Boundary scan TAP in the middle, facing the I/O pins
    jcd_tap #(.DW(BSR_W), .HAS_BSR(1), .ID_WORD(ID_WORD)) u_bsr_tap (
        .mclk          (mclk),
        .rstn          (rstn),
        .tck_rise      (tck_rise),
        .tms           (tms_s2_reg),
        .tdi           (dbg_so),
        .user_word     (user_word),
        .cap_data      (pin_in),
        .so            (bsr_so),
        .upd_data_reg  (pin_out),
        .upd_pulse_reg (),
        .extest_reg    (pin_extest),
        .shifting      (shift_vec[1])
    );

    // Processor TAP, last on the chain, facing tile, switch and OTP
    jcd_tap #(.DW(TILE_W), .HAS_BSR(0), .ID_WORD(ID_WORD)) u_proc_tap (
        .mclk          (mclk),
        .rstn          (rstn),
        .tck_rise      (tck_rise),
        .tms           (tms_s2_reg),
        .tdi           (bsr_so),
        .user_word     (user_word),
        .cap_data      (tile_rd_data),
        .so            (proc_so),
        .upd_data_reg  (tile_wr_data),
        .upd_pulse_reg (tile_wr_stb),
        .extest_reg    (),
        .shifting      (shift_vec[2])
    );

    // TDO changes on the falling TCK edge, driven only while shifting
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            jtag_tdo    <= 1'b0;
            jtag_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            jtag_tdo    <= proc_so;
            jtag_tdo_oe <= |shift_vec;
        end
    end

    // Debug sync pin: open drain, low once a breakpoint is hit
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dbg_sync_out <= `JCD_PIN_LOW;
            dbg_sync_oe  <= `JCD_SYNC_IDLE;
            force_debug  <= 1'b0;
        end else begin
            dbg_sync_out <= `JCD_PIN_LOW;
            if (!sync_drive_en) begin
                dbg_sync_oe <= 1'b0;
            end else if (bkpt_hit) begin
                dbg_sync_oe <= 1'b1;
            end
            force_debug <= sync_listen_en & ~sync_s2_reg;
        end
    end
endmodule
`default_nettype wire

//--- testbench/jcd_monitor.sv
// Checker for the test port chain and the debug sync pin.
// Assumes it is bound to jcd_jtag_chain; one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module jcd_monitor (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic jtag_tck,
    input wire logic jtag_tms,
    input wire logic jtag_tdo,
    input wire logic jtag_tdo_oe,
    input wire logic dbg_sync_in,
    input wire logic dbg_sync_oe,
    input wire logic sync_drive_en,
    input wire logic sync_listen_en,
    input wire logic bkpt_hit,
    input wire logic force_debug,
    input wire logic per_wr_stb,
    input wire logic tile_wr_stb,
    input wire logic pin_extest
);
    logic       tck_q_reg;
    logic [2:0] hi_cnt_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ====================
    // Count test clock rises seen with TMS high
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tck_q_reg <= 1'b0;
            hi_cnt_reg <= 3'h0;
        end else begin
            tck_q_reg <= jtag_tck;
            if (jtag_tck && !tck_q_reg)
                hi_cnt_reg <= !jtag_tms ? 3'h0 : (hi_cnt_reg == 3'h5 ? 3'h5 : hi_cnt_reg + 3'h1);
        end
    end

    // ====================
    // Properties
    tlr_clear_a: assert property ($rose(hi_cnt_reg == 3'h5) |-> ##[1:6] !pin_extest)
        else $error("boundary test mode survived port reset");
    tdo_fall_a: assert property ($changed({jtag_tdo, jtag_tdo_oe}) |-> !jtag_tck)
        else $error("test data out moved while test clock high");
    sync_drive_a: assert property (sync_drive_en && bkpt_hit |=> dbg_sync_oe)
        else $error("sync pin not pulled after breakpoint");
    sync_idle_a: assert property (!sync_drive_en |=> !dbg_sync_oe)
        else $error("sync pin pulled with output mode off");
    sync_cause_a: assert property ($rose(dbg_sync_oe) |-> $past(bkpt_hit) && $past(sync_drive_en))
        else $error("sync pin pulled without breakpoint");
    force_set_a: assert property ((sync_listen_en && !dbg_sync_in) [*4] |-> force_debug)
        else $error("low sync pin did not force debug");
    force_clear_a: assert property (dbg_sync_in [*4] |-> !force_debug)
        else $error("debug forced with sync pin high");
    force_quiet_a: assert property (!sync_listen_en [*3] |-> !force_debug)
        else $error("debug forced with input mode off");
    stb_pulse_a: assert property (per_wr_stb || tile_wr_stb |=> !(per_wr_stb || tile_wr_stb))
        else $error("write strobe longer than one cycle");
    cover property ($rose(dbg_sync_oe));
    cover property ($rose(force_debug));
    cover property (per_wr_stb);
endmodule

bind jcd_jtag_chain jcd_monitor mon (.mclk, .rstn, .jtag_tck, .jtag_tms, .jtag_tdo, .jtag_tdo_oe, .dbg_sync_in,
    .dbg_sync_oe, .sync_drive_en, .sync_listen_en, .bkpt_hit, .force_debug, .per_wr_stb, .tile_wr_stb, .pin_extest);
`default_nettype wire

//--- testbench/jcd_host.sv
// Test port host and neighbour processor model.
// Assumes the bench calls its tasks; sync wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module jcd_host (
    output logic      jtag_tck,
    output logic      jtag_tms,
    output logic      jtag_tdi,
    input  wire logic jtag_tdo,
    input  wire logic dbg_sync_oe,
    output wire logic dbg_sync_in
);
    logic other_oe = 1'b0;
    // Open-drain wire, pulled up when nobody pulls
    assign dbg_sync_in = (dbg_sync_oe || other_oe) ? 1'b0 : 1'b1;
    // Test clock stands low between frames
    initial begin
        jtag_tck = 1'b0;
        jtag_tms = 1'b1;
        jtag_tdi = 1'b0;
    end
    // One test clock, data out taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        jtag_tms = m;
        jtag_tdi = d;
        #80 jtag_tck = 1'b1;
        o = jtag_tdo;
        #80 jtag_tck = 1'b0;
    endtask
    // Five TMS-high clocks, then on to idle
    task automatic tap_reset();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
    // Scan n bits, LSB first, from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] di, output logic [127:0] dq);
        logic o;
        dq = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) step(i == n - 1, di[i], dq[i]);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule
`default_nettype wire

//--- testbench/jcd_jtag_chain_tb.sv
// Self-checking bench for the test port chain and sync pin.
// Assumes jcd_host drives the port; mclk-side inputs from here.
`timescale 1ns/1ps
`default_nettype none
module jcd_jtag_chain_tb;
    localparam logic [31:0] ID_WORD = {4'h1, 16'h0A5C, 11'h2B4, 1'b1};
    logic mclk, rstn, jtag_tck, jtag_tms, jtag_tdi, jtag_tdo, jtag_tdo_oe, dbg_sync_in, dbg_sync_out, dbg_sync_oe;
    logic sync_drive_en, sync_listen_en, bkpt_hit, force_debug, per_wr_stb, tile_wr_stb, pin_extest;
    logic [15:0]  otp_user_id, pin_in, pin_out, c;
    logic [31:0]  per_rd_data, per_wr_data, tile_rd_data, tile_wr_data, a, b;
    logic [31:0]  q_per[$], q_tile[$];
    logic [127:0] q;
    int           seed = 68;
    int           n_tests = 0;
    int           n_mismatch = 0;

    jcd_jtag_chain dut (.mclk, .rstn, .jtag_tck, .jtag_tms, .jtag_tdi, .jtag_tdo, .jtag_tdo_oe, .dbg_sync_in,
        .dbg_sync_out, .dbg_sync_oe, .sync_drive_en, .sync_listen_en, .bkpt_hit, .force_debug, .otp_user_id,
        .per_rd_data, .per_wr_data, .per_wr_stb, .tile_rd_data, .tile_wr_data, .tile_wr_stb, .pin_in, .pin_out,
        .pin_extest);
    jcd_host host (.jtag_tck, .jtag_tms, .jtag_tdi, .jtag_tdo, .dbg_sync_oe, .dbg_sync_in);

    // ====================
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
    // Write strobes take the oldest expected word
    always @(posedge mclk) begin
        if (per_wr_stb) check(per_wr_data, q_per.pop_front());
        if (tile_wr_stb) check(tile_wr_data, q_tile.pop_front());
    end

    // ====================
    // Main sequence
    initial begin
        rstn = 1'b0;
        {sync_drive_en, sync_listen_en, bkpt_hit} = 3'b000;
        {otp_user_id, pin_in, per_rd_data, tile_rd_data} = '0;
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        host.tap_reset();
        fork
            host.scan(1'b0, 96, 128'h0, q);
            begin
                repeat (40) @(negedge mclk);
                check(jtag_tdo_oe, 1'b1);
            end
        join
        check(q[95:0], {3{ID_WORD}});
        check(jtag_tdo_oe, 1'b0);
        otp_user_id = $random(seed);
        host.scan(1'b1, 12, 128'h333, q);
        check(q[11:0], 12'h111);
        host.scan(1'b0, 96, 128'h0, q);
        check(q[95:0], {3{otp_user_id, 12'h000, 4'h1}});
        // Access scan through debug and processor paths
        per_rd_data = $random(seed);
        tile_rd_data = $random(seed);
        a = $random(seed);
        b = $random(seed);
        q_per.push_back(a);
        q_tile.push_back(b);
        host.scan(1'b1, 12, 128'h4F4, q);
        host.scan(1'b0, 65, {a, 1'b0, b}, q);
        check(q[64:0], {per_rd_data, 1'b0, tile_rd_data});
        // Boundary scan, then port reset mid-test
        pin_in = $random(seed);
        c = $random(seed);
        host.scan(1'b1, 12, 128'hF0F, q);
        check(pin_extest, 1'b1);
        host.scan(1'b0, 18, {1'b0, c, 1'b0}, q);
        check(q[17:0], {1'b0, pin_in, 1'b0});
        check(pin_out, c);
        host.tap_reset();
        repeat (4) @(negedge mclk);
        check(pin_extest, 1'b0);
        host.scan(1'b0, 96, 128'h0, q);
        check(q[95:0], {3{ID_WORD}});
        // Sync pin in output then input mode
        bkpt_hit = 1'b1;
        repeat (3) @(negedge mclk);
        check(dbg_sync_oe, 1'b0);
        sync_drive_en = 1'b1;
        @(negedge mclk);
        bkpt_hit = 1'b0;
        check(dbg_sync_in, 1'b0);
        repeat (3) @(negedge mclk);
        check(dbg_sync_oe, 1'b1);
        check(dbg_sync_out, 1'b0);
        sync_drive_en = 1'b0;
        repeat (2) @(negedge mclk);
        check(dbg_sync_oe, 1'b0);
        host.other_oe = 1'b1;
        repeat (6) @(negedge mclk);
        check(force_debug, 1'b0);
        sync_listen_en = 1'b1;
        repeat (6) @(negedge mclk);
        check(force_debug, 1'b1);
        host.other_oe = 1'b0;
        repeat (6) @(negedge mclk);
        check(force_debug, 1'b0);
        check(q_per.size() + q_tile.size(), 0);
        give_verdict();
    end
endmodule
`default_nettype wire
